// ===== pror_pkg.sv
// What this block does
// - writing 1 starts matching peripheral reset
// - field reads 1 until reset completes
// - bit 1 resets the watchdog
// - bit 0 resets the transfer block
// - bit 31 set when external clock ready
// - external ready flag resets to 1
// - bits 29..27 show oscillator ready state
package pror_pkg;

    // register port geometry
    localparam int ADDR_W = 8;                              // byte address width
    localparam int DATA_W = 32;                             // data word width

    // register byte offsets
    localparam logic [ADDR_W-1:0] RST0_OFS   = 8'h04;       // peripheral reset register
    localparam logic [ADDR_W-1:0] CLKCTL_OFS = 8'h08;       // clock control register

    // reset register layout
    localparam int RST_FIELDS = 15;                         // bits 14..0 handled here
    localparam logic [RST_FIELDS-1:0] RST_MASK = 15'h78e7;  // defined reset fields
    localparam logic [RST_FIELDS-1:0] RST_RESET = 15'h0000; // all fields idle at reset

    // clock control layout
    localparam int EXT_RDY_BIT  = 31;                       // external clock ready
    localparam int RSV30_BIT    = 30;                       // reserved, reads 1
    localparam int OSC_RDY_HI   = 29;                       // low-power oscillator ready
    localparam int OSC_RDY_LO   = 27;                       // primary oscillator ready
    localparam int RSV26_BIT    = 26;                       // reserved, reads 0
    localparam logic EXT_RDY_RESET = 1'b1;                  // external flag after reset
    localparam logic [2:0] OSC_RDY_RESET = 3'h0;            // oscillator flags after reset
    localparam logic RSV30_VAL = 1'b1;                      // fixed value of bit 30
    localparam logic RSV26_VAL = 1'b0;                      // fixed value of bit 26

    // peripheral reset pulse length
    localparam int CLK_PERIOD_NS = 10;                      // 100 MHz system clock
    localparam int RST_HOLD_NS   = 80;                      // least reset pulse time
    localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;                            // byte address
        logic [DATA_W-1:0] wdata;                           // write data
        logic              wr;                              // write strobe
        logic              rd;                              // read strobe
    } pror_bus_req_t;

    // per-peripheral reset lines, packed in register bit order
    typedef struct packed {
        logic       serial_port_b_reset;                    // bit 14
        logic       serial_port_a_reset;                    // bit 13
        logic       async_serial_b_reset;                   // bit 12
        logic       async_serial_a_reset;                   // bit 11
        logic [2:0] rsvd_10_8;                              // reserved, always 0
        logic       timer_c_reset;                          // bit 7
        logic       timer_b_reset;                          // bit 6
        logic       timer_a_reset;                          // bit 5
        logic [1:0] rsvd_4_3;                               // reserved, always 0
        logic       io_port_reset;                          // bit 2
        logic       watchdog_a_reset;                       // bit 1
        logic       transfer_block_reset;                   // bit 0
    } pror_resets_t;

    // ready levels from clock sources
    typedef struct packed {
        logic external_clock_pin;                           // external clock usable
        logic lowpower_osc;                                 // low-power oscillator
        logic backup_osc;                                   // backup oscillator
        logic primary_osc;                                  // primary oscillator
    } pror_ready_t;

endpackage : pror_pkg

// ===== pror_reset_chan.sv
`timescale 1ns/10ps
// one self-clearing reset field and the pulse it drives
module pror_reset_chan #(
    parameter int HOLD = pror_pkg::RST_HOLD_CYC             // pulse length in cycles
) (
    input  wire logic clk,                                  // system clock
    input  wire logic reset_n,                              // synchronous reset, low
    input  wire logic start,                                // one-cycle start request
    output logic      busy                                  // field value and reset line
);
    import pror_pkg::*;

    localparam int CNT_W = $clog2(HOLD + 1);                // counter width

    typedef enum logic {CH_IDLE, CH_HOLD} pror_chan_t;      // channel states

    pror_chan_t       state_r, state_nxt;                   // channel state
    logic [CNT_W-1:0] cnt_r, cnt_nxt;                       // cycles left in pulse
    logic             busy_r, busy_nxt;                     // registered busy

    // next state: a start before the closing cycle of a pulse is ignored and does not stretch it;
    // a start on the closing cycle restarts it, since the request must not be lost
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        busy_nxt  = busy_r;
        case (state_r)
            CH_IDLE:
            begin
                if (start)
                begin
                    state_nxt = CH_HOLD;
                    cnt_nxt   = CNT_W'(HOLD - 1);
                    busy_nxt  = 1'b1;
                end
            end
            CH_HOLD:
            begin
                if (cnt_r == '0 && start)                   // request wins over self-clear
                begin
                    cnt_nxt = CNT_W'(HOLD - 1);
                end
                else if (cnt_r == '0)                       // pulse done, self-clear
                begin
                    state_nxt = CH_IDLE;
                    busy_nxt  = 1'b0;
                end
                else
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default:
            begin
                state_nxt = CH_IDLE;
                busy_nxt  = 1'b0;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_r <= CH_IDLE;
            cnt_r   <= '0;
            busy_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            busy_r  <= busy_nxt;
        end
    end

    assign busy = busy_r;

    sequence s_pulse;
        busy [*8] ##1 (!busy || $past(start));
    endsequence

    a_pulse_hold_length: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(busy) |-> s_pulse)
        else $error("reset pulse length wrong");

    a_start_sets_busy: assert property (@(posedge clk) disable iff (!reset_n)
        (start && !busy) |=> busy)
        else $error("start did not raise busy");

endmodule : pror_reset_chan

// ===== pror_test.sv
`timescale 1ns/10ps
// self-checking bench for the peripheral reset fields and clock ready flags
module pror_test;
    import pror_pkg::*;

    `define CHECK(what, expv, gotv) \
    begin \
        cmp_count++; \
        if ((gotv) !== (expv)) \
        begin \
            mismatches++; \
            $display("MISMATCH %s expected %h seen %h", what, expv, gotv); \
        end \
    end

    logic                  clk;          // system clock
    logic                  reset_n;      // synchronous reset, low
    pror_bus_req_t         busReq;       // register request
    logic [DATA_W-1:0]     readData;     // read data from block
    pror_ready_t           readyIn;      // ready levels into block
    pror_resets_t          periphResets; // reset lines out of block
    integer                seed;         // fixed random seed
    int                    mismatches;   // failed comparisons
    int                    cmp_count;    // all comparisons
    logic [DATA_W-1:0]     rnd;          // random draw
    logic [DATA_W-1:0]     rdVal;        // value returned by a read
    logic [RST_FIELDS-1:0] expRst;       // expected reset lines

    pror_top pror_top_inst (
        .clk          (clk),
        .reset_n      (reset_n),
        .busReq       (busReq),
        .readData     (readData),
        .readyIn      (readyIn),
        .periphResets (periphResets)
    );

    // free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // expected clock control word; bits outside 31..26 read 0
    function automatic logic [DATA_W-1:0] exp_clk(input pror_ready_t r);
        exp_clk = {r.external_clock_pin, RSV30_VAL, r.lowpower_osc, r.backup_osc,
                   r.primary_osc, RSV26_VAL, 26'h0};
    endfunction : exp_clk

    // one write cycle, request held for exactly one edge
    task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq <= '0;
        #1;
    endtask : bus_write

    // one read cycle; data is only valid in the cycle after the strobe
    task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq <= '0;
        #1;
        d = readData;
    endtask : bus_read

    // count the cycles the lines stay high; bounded so a stuck line ends the run
    task automatic pulse_len(input int expLen);
        int n;
        n = 0;
        while (periphResets !== '0 && n < 50)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 50)
        begin
            mismatches++;
            give_verdict();
        end
        else
        begin
            `CHECK("pulse length", expLen, n)
        end
    endtask : pulse_len

    // single place where the run ends
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    // main sequence
    initial
    begin
        seed = 42;
        mismatches = 0;
        cmp_count = 0;
        busReq = '0;
        readyIn = '0;
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        // read on the first edge after release sees the flag reset values
        reset_n <= 1'b1;
        busReq <= '{addr: CLKCTL_OFS, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq <= '0;
        #1;
        rnd = {EXT_RDY_RESET, RSV30_VAL, OSC_RDY_RESET, RSV26_VAL, 26'h0};
        `CHECK("clock ctl reset", rnd, readData)
        bus_read(RST0_OFS, rdVal);
        `CHECK("reset reg reset", RST_RESET, rdVal[RST_FIELDS-1:0])
        bus_read(8'h0c, rdVal);
        `CHECK("unmapped read", 32'h0, rdVal)
        // ready flags follow inputs, corners then random
        for (int i = 0; i < 18; i++)
        begin
            rnd = (i == 0) ? 32'h0 : (i == 1) ? 32'hf : $random(seed);
            @(posedge clk);
            readyIn <= pror_ready_t'(rnd[3:0]);
            bus_read(CLKCTL_OFS, rdVal);
            `CHECK("clock ctl flags", exp_clk(readyIn), rdVal)
        end
        bus_write(CLKCTL_OFS, 32'hffffffff);
        bus_read(CLKCTL_OFS, rdVal);
        `CHECK("clock ctl write", exp_clk(readyIn), rdVal)
        // read data stands for one cycle only, then falls back to zero
        @(posedge clk);
        #1;
        `CHECK("read data idle", 32'h0, readData)
        // each field alone, reserved positions included
        for (int i = 0; i < RST_FIELDS; i++)
        begin
            bus_write(RST0_OFS, 32'h1 << i);
            expRst = (15'h1 << i) & RST_MASK;
            `CHECK("reset lines", expRst, periphResets)
            bus_read(RST0_OFS, rdVal);
            `CHECK("reset readback", expRst, rdVal[RST_FIELDS-1:0])
            pulse_len((expRst != '0) ? RST_HOLD_CYC - 2 : 0);
        end
        // a second request during the pulse must not stretch it
        bus_write(RST0_OFS, 32'h2);
        bus_write(RST0_OFS, 32'h2);
        pulse_len(RST_HOLD_CYC - 2);
        bus_write(RST0_OFS, 32'h0);
        `CHECK("zero write", 15'h0, periphResets)
        // random words, reserved bits set at random too
        for (int i = 0; i < 12; i++)
        begin
            rnd = $random(seed);
            bus_write(RST0_OFS, rnd);
            expRst = rnd[RST_FIELDS-1:0] & RST_MASK;
            `CHECK("random lines", expRst, periphResets)
            bus_read(RST0_OFS, rdVal);
            `CHECK("random readback", expRst, rdVal[RST_FIELDS-1:0])
            pulse_len((expRst != '0) ? RST_HOLD_CYC - 2 : 0);
        end
        // system reset in mid-pulse drops the line
        bus_write(RST0_OFS, 32'h20);
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        #1;
        `CHECK("reset mid pulse", 15'h0, periphResets)
        bus_read(RST0_OFS, rdVal);
        `CHECK("reset reg after", 15'h0, rdVal[RST_FIELDS-1:0])
        give_verdict();
    end

endmodule : pror_test

// ===== pror_top.sv
// Design decision made here: strobed register access.
`timescale 1ns/10ps
// peripheral reset fields and clock ready flags behind a simple register port
module pror_top (
    input  wire logic                 clk,          // system clock, 100 MHz
    input  wire logic                 reset_n,      // synchronous reset, low
    input  wire pror_pkg::pror_bus_req_t busReq,    // register request
    output logic [pror_pkg::DATA_W-1:0] readData,   // read data, cycle after read
    input  wire pror_pkg::pror_ready_t readyIn,     // ready levels from clocks
    output pror_pkg::pror_resets_t    periphResets  // reset lines, high active
);
    import pror_pkg::*;

    // decoded strobes
    logic                  hitRst;                  // address is reset register
    logic                  hitClk;                  // address is clock control
    logic [RST_FIELDS-1:0] startVec;                // per-field start pulses
    logic [RST_FIELDS-1:0] busyVec;                 // per-field busy levels

    // ready flag state
    logic       extRdy_r, extRdy_nxt;               // external clock ready flag
    logic [2:0] oscRdy_r, oscRdy_nxt;               // oscillator ready flags

    // read data state
    logic [DATA_W-1:0] readData_r, readData_nxt;    // registered read data

    // address decode, if chain per the house style
    always_comb
    begin
        hitRst = 1'b0;
        hitClk = 1'b0;
        if (busReq.addr == RST0_OFS)
        begin
            hitRst = 1'b1;
        end
        else if (busReq.addr == CLKCTL_OFS)
        begin
            hitClk = 1'b1;
        end
    end

    // only defined fields can start; reserved write bits fall away here
    always_comb
    begin
        startVec = '0;
        if (busReq.wr && hitRst)
        begin
            startVec = busReq.wdata[RST_FIELDS-1:0] & RST_MASK;
        end
    end

    // one channel per defined field; reserved positions stay tied low
    genvar gi;
    generate
        for (gi = 0; gi < RST_FIELDS; gi++)
        begin : g_chan
            if (RST_MASK[gi])
            begin : g_live
                pror_reset_chan #(
                    .HOLD    (RST_HOLD_CYC)
                ) u_chan (
                    .clk     (clk),
                    .reset_n (reset_n),
                    .start   (startVec[gi]),
                    .busy    (busyVec[gi])
                );
            end
            else
            begin : g_rsvd
                assign busyVec[gi] = 1'b0;
            end
        end
    endgenerate

    // the busy flops drive the peripheral lines directly, no extra delay
    assign periphResets = pror_resets_t'(busyVec);

    // ready flags: one flop each, so a read sees the level of the cycle before
    always_comb
    begin
        extRdy_nxt = readyIn.external_clock_pin;
        oscRdy_nxt = {readyIn.lowpower_osc,
                      readyIn.backup_osc,
                      readyIn.primary_osc};
    end

    // ready flag registers; the external flag comes out of reset as 1
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            extRdy_r <= EXT_RDY_RESET;
            oscRdy_r <= OSC_RDY_RESET;
        end
        else
        begin
            extRdy_r <= extRdy_nxt;
            oscRdy_r <= oscRdy_nxt;
        end
    end

    // read mux; unmapped addresses and idle cycles read as zero
    always_comb
    begin
        readData_nxt = '0;
        if (busReq.rd)
        begin
            if (hitRst)
            begin
                readData_nxt[RST_FIELDS-1:0] = busyVec;
            end
            else if (hitClk)
            begin
                readData_nxt[EXT_RDY_BIT] = extRdy_r;
                readData_nxt[RSV30_BIT]   = RSV30_VAL;
                readData_nxt[OSC_RDY_HI:OSC_RDY_LO] = oscRdy_r;
                readData_nxt[RSV26_BIT]   = RSV26_VAL;
            end
        end
    end

    // read data register, valid only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            readData_r <= '0;
        end
        else
        begin
            readData_r <= readData_nxt;
        end
    end

    assign readData = readData_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // helpers: reset register write and read, clock control read
    logic wrRst;                                   // reset register write
    logic rdRst;                                   // reset register read
    logic rdClk;                                   // clock control read
    assign wrRst = busReq.wr && hitRst;
    assign rdRst = busReq.rd && hitRst;
    assign rdClk = busReq.rd && hitClk;

    sequence s_wdog_pulse;
        periphResets.watchdog_a_reset [*8] ##1 !periphResets.watchdog_a_reset;
    endsequence

    sequence s_xfer_clear;
        periphResets.transfer_block_reset [*8] ##1 !periphResets.transfer_block_reset;
    endsequence

    a_write_starts_reset: assert property (
        wrRst |=> ((busyVec & $past(busReq.wdata[RST_FIELDS-1:0]) & RST_MASK)
                   == ($past(busReq.wdata[RST_FIELDS-1:0]) & RST_MASK)))
        else $error("written field did not start reset");

    a_read_shows_busy: assert property (
        rdRst |=> (readData[RST_FIELDS-1:0] == $past(busyVec)))
        else $error("reset field readback wrong");

    a_watchdog_self_clear: assert property (
        (wrRst && busReq.wdata[1] && !periphResets.watchdog_a_reset) |=> s_wdog_pulse)
        else $error("watchdog reset pulse wrong");

    a_transfer_self_clear: assert property (
        (wrRst && busReq.wdata[0] && !periphResets.transfer_block_reset)
        |=> s_xfer_clear)
        else $error("transfer block reset did not self-clear");

    a_ext_ready_follows: assert property (
        (rdClk && $past(reset_n)) |=> (readData[EXT_RDY_BIT]
                                        == $past(readyIn.external_clock_pin, 2)))
        else $error("external ready flag wrong");

    a_ext_ready_reset: assert property (@(posedge clk) disable iff (1'b0)
        !reset_n |=> extRdy_r)
        else $error("external ready flag not 1 after reset");

    a_osc_ready_follows: assert property (
        (rdClk && $past(reset_n)) |=> (readData[OSC_RDY_HI:OSC_RDY_LO]
            == $past({readyIn.lowpower_osc, readyIn.backup_osc, readyIn.primary_osc}, 2)))
        else $error("oscillator ready flags wrong");

    a_reserved_fixed: assert property (
        (rdClk |=> (readData[RSV30_BIT] && !readData[RSV26_BIT]))
        and (rdRst |=> (readData[10:8] == 3'h0 && readData[4:3] == 2'h0)))
        else $error("reserved bits read wrong");

    a_reserved_no_line: assert property (
        periphResets.rsvd_10_8 == 3'h0 && periphResets.rsvd_4_3 == 2'h0)
        else $error("reserved reset line driven");

endmodule : pror_top
